// ---- spp_port.sv ----
// top: shared pin priority port with apb register access
// What this block does
// - only enabled signals arbitrate; highest wins
// - routed signal competes only at selected pin
// - general output ranks below all peripherals
// - peripheral inputs always see pin level
// - readback returns sampled pin level always
// - direction bit set means output pin
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spp_port
   import spp_pkg::*;
#(
   parameter int PINS = spp_pkg::SPP_PINS
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral a per pin
   input wire logic [PINS-1:0] periph_a_oe,
   input wire logic [PINS-1:0] periph_a_out,
   // peripheral b per pin
   input wire logic [PINS-1:0] periph_b_oe,
   input wire logic [PINS-1:0] periph_b_out,
   // routed peripheral, one signal steerable to any pin
   input wire logic routed_oe,
   input wire logic routed_out,
   // peripheral input view of the pins
   output logic [PINS-1:0] periph_in,
   // pads
   input wire logic [PINS-1:0] pad_in,
   output logic [PINS-1:0] pad_out,
   output logic [PINS-1:0] pad_oe
);
   import spp_pkg::*;

   // ======================================================================
   // elaboration check
   if (PINS != 8) begin : g_bad_pins
      $error("spp_port supports exactly eight pins");
   end

   // ======================================================================
   // registers
   logic [7:0] direction_r;
   logic [7:0] gen_out_data_r;
   logic [7:0] periph_en_r;
   logic [7:0] route_sel_r;
   logic [7:0] sync1_r;
   logic [7:0] sync2_r;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rdata_nxt;

   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & ~penable & ~pwrite;
   assign addr_ok = (paddr == SPP_OFF_READBACK) || (paddr == SPP_OFF_DIRECTION) ||
      (paddr == SPP_OFF_GEN_OUT_DATA) || (paddr == SPP_OFF_PERIPH_EN) ||
      (paddr == SPP_OFF_ROUTE_SEL);

   // pad level synchroniser; first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
      end
   end

   // software writes land at the access edge, where the master sees ready;
   // a setup cycle alone never changes state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         direction_r <= SPP_DIRECTION_RST;
         gen_out_data_r <= SPP_GEN_OUT_DATA_RST;
         periph_en_r <= SPP_PERIPH_EN_RST;
         route_sel_r <= SPP_ROUTE_SEL_RST;
      end else if (wr_en) begin
         unique case (paddr)
            SPP_OFF_DIRECTION: direction_r <= pwdata[7:0];
            SPP_OFF_GEN_OUT_DATA: gen_out_data_r <= pwdata[7:0];
            SPP_OFF_PERIPH_EN: periph_en_r <= pwdata[7:0];
            SPP_OFF_ROUTE_SEL: route_sel_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // read mux
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr)
         SPP_OFF_READBACK: rdata_nxt = {24'h00_0000, sync2_r};
         SPP_OFF_DIRECTION: rdata_nxt = {24'h00_0000, direction_r};
         SPP_OFF_GEN_OUT_DATA: rdata_nxt = {24'h00_0000, gen_out_data_r};
         SPP_OFF_PERIPH_EN: rdata_nxt = {24'h00_0000, periph_en_r};
         SPP_OFF_ROUTE_SEL: rdata_nxt = {24'h00_0000, route_sel_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // apb answer registered in setup, so the access phase sees it at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (rd_en) begin
            prdata <= addr_ok ? rdata_nxt : 32'h0000_0000;
         end
      end
   end

   // ======================================================================
   // per pin arbitration
   logic [7:0] a_en;
   logic [7:0] b_en;
   logic [7:0] b_oe_m;
   logic [7:0] b_out_m;
   logic [7:0] arb_oe;
   logic [7:0] arb_out;
   logic [SPP_ROUTE_W-1:0] route_pin;

   assign route_pin = route_sel_r[SPP_ROUTE_LSB +: SPP_ROUTE_W];

   // enable of the b slot: pins 4..6 share b with the routed signal,
   // which sits above b only at its selected pin
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         a_en[i] = (i < 4) ? periph_en_r[SPP_EN_A_LSB + (i % 4)] : 1'b0;
         b_en[i] = (i >= 4 && i < 7) ? periph_en_r[SPP_EN_B_LSB + (i % 4)] : 1'b0;
         b_oe_m[i] = periph_b_oe[i];
         b_out_m[i] = periph_b_out[i];
         if (periph_en_r[SPP_EN_ROUTED_BIT] && (route_pin == i[SPP_ROUTE_W-1:0])) begin
            b_en[i] = 1'b1;
            b_oe_m[i] = routed_oe;
            b_out_m[i] = routed_out;
         end
      end
   end

   for (genvar g = 0; g < 8; g++) begin : g_pin
      spp_pin_arb u_arb (
         .a_en(a_en[g]),
         .a_oe(periph_a_oe[g]),
         .a_out(periph_a_out[g]),
         .b_en(b_en[g]),
         .b_oe(b_oe_m[g]),
         .b_out(b_out_m[g]),
         .gen_out_dir(direction_r[g]),
         .gen_out_val(gen_out_data_r[g]),
         .pin_oe(arb_oe[g]),
         .pin_out(arb_out[g])
      );
   end

   // pad drive registered so outputs come from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_oe <= 8'h00;
         pad_out <= 8'h00;
      end else begin
         pad_oe <= arb_oe;
         pad_out <= arb_out;
      end
   end

   // inputs see pin level, independent of owner or enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_in <= 8'h00;
      end else begin
         periph_in <= sync2_r;
      end
   end
endmodule // spp_port
`default_nettype wire

// ---- spp_pkg.sv ----
// package: register map, field layout and reset values for the shared pin port
package spp_pkg;
   // ======================================================================
   // register offsets (byte addresses on apb)
   localparam logic [11:0] SPP_OFF_READBACK = 12'h000;
   localparam logic [11:0] SPP_OFF_DIRECTION = 12'h004;
   localparam logic [11:0] SPP_OFF_GEN_OUT_DATA = 12'h008;
   localparam logic [11:0] SPP_OFF_PERIPH_EN = 12'h00C;
   localparam logic [11:0] SPP_OFF_ROUTE_SEL = 12'h010;
   // ======================================================================
   // widths and reset values
   localparam int SPP_PINS = 8;
   localparam logic [7:0] SPP_DIRECTION_RST = 8'h00;
   localparam logic [7:0] SPP_GEN_OUT_DATA_RST = 8'h00;
   localparam logic [7:0] SPP_PERIPH_EN_RST = 8'h00;
   localparam logic [7:0] SPP_ROUTE_SEL_RST = 8'h00;
   // field positions in the peripheral enable register
   localparam int SPP_EN_A_LSB = 0;
   localparam int SPP_EN_B_LSB = 4;
   // routed signal enable position
   localparam int SPP_EN_ROUTED_BIT = 7;
   // routing select field: target pin index in low three bits
   localparam int SPP_ROUTE_LSB = 0;
   localparam int SPP_ROUTE_W = 3;
endpackage : spp_pkg

// ---- spp_pin_arb.sv ----
// single pin priority arbiter: peripheral a over peripheral b over general output
`timescale 1ns/1ps
`default_nettype none
module spp_pin_arb (
   // peripheral a request
   input wire logic a_en,
   input wire logic a_oe,
   input wire logic a_out,
   // peripheral b request
   input wire logic b_en,
   input wire logic b_oe,
   input wire logic b_out,
   // general output function from port registers
   input wire logic gen_out_dir,
   input wire logic gen_out_val,
   // resolved pin drive
   output logic pin_oe,
   output logic pin_out
);
   // ======================================================================
   // fixed priority selection
   always_comb begin
      if (a_en) begin
         pin_oe = a_oe;
         pin_out = a_out;
      end else if (b_en) begin
         pin_oe = b_oe;
         pin_out = b_out;
      end else begin
         pin_oe = gen_out_dir;
         pin_out = gen_out_val;
      end
   end
endmodule // spp_pin_arb
`default_nettype wire

// ---- spp_port_sva.sv ----
// checker: port level assertions for the shared pin port
`timescale 1ns/1ps
`default_nettype none
module spp_port_sva
   import spp_pkg::*;
#(
   parameter int PINS = 8
) (
   // clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // pins
   input wire logic [PINS-1:0] periph_in,
   input wire logic [PINS-1:0] pad_in,
   input wire logic [PINS-1:0] pad_out,
   input wire logic [PINS-1:0] pad_oe
);
   // ======================================================================
   // helpers: cycles since reset, cycles pad level unchanged
   logic [2:0] age_r;
   logic [2:0] stab_r;
   // set at the first edge; registers are unknown before reset has seen a clock
   logic live_r = 1'b0;
   always @(posedge pclk) live_r <= 1'b1;
   // bus shadows of enable, direction and output data, taken at the access edge
   logic [7:0] en_sh_r;
   logic [7:0] dir_sh_r;
   logic [7:0] dat_sh_r;
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite && pready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_sh_r <= SPP_PERIPH_EN_RST;
         dir_sh_r <= SPP_DIRECTION_RST;
         dat_sh_r <= SPP_GEN_OUT_DATA_RST;
      end else if (wr_acc) begin
         if (paddr == SPP_OFF_PERIPH_EN) en_sh_r <= pwdata[7:0];
         if (paddr == SPP_OFF_DIRECTION) dir_sh_r <= pwdata[7:0];
         if (paddr == SPP_OFF_GEN_OUT_DATA) dat_sh_r <= pwdata[7:0];
      end
   end
   // saturate so the sync pipeline has filled before checks start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age_r <= 3'h0;
      else if (age_r != 3'h7) age_r <= age_r + 3'h1;
   end
   // pad level steady long enough to have crossed both sync stages
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stab_r <= 3'h0;
      else if (pad_in != $past(pad_in)) stab_r <= 3'h0;
      else if (stab_r != 3'h7) stab_r <= stab_r + 3'h1;
   end
   // ======================================================================
   // properties
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready;
   endsequence
   property p_answer;
      @(posedge pclk) disable iff (!presetn) s_setup |=> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   property p_rst_out;
      @(posedge pclk) !presetn && live_r |-> pad_oe == '0 && pad_out == '0;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("pads driven in reset");
   property p_pin_view;
      @(posedge pclk) disable iff (!presetn) age_r > 3'h4 |-> periph_in == $past(pad_in, 3);
   endproperty
   a_pin_view: assert property (p_pin_view) else $error("input view lost");
   property p_readback;
      @(posedge pclk) disable iff (!presetn)
         s_answer and (!pwrite && paddr == SPP_OFF_READBACK && stab_r > 3'h3)
         |-> prdata[7:0] == pad_in;
   endproperty
   a_readback: assert property (p_readback) else $error("readback wrong");
   // with nothing enabled, pad direction follows the direction register
   property p_dir_bit;
      @(posedge pclk) disable iff (!presetn)
         $past(en_sh_r) == 8'h00 |-> pad_oe == $past(dir_sh_r);
   endproperty
   a_dir_bit: assert property (p_dir_bit) else $error("direction not obeyed");
   // with nothing enabled, the general output data owns the pad value
   property p_gen_low;
      @(posedge pclk) disable iff (!presetn)
         $past(en_sh_r) == 8'h00 |-> pad_out == $past(dat_sh_r);
   endproperty
   a_gen_low: assert property (p_gen_low) else $error("general output lost");
endmodule // spp_port_sva
bind spp_port spp_port_sva #(.PINS(PINS)) u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready), .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe(pad_oe));
`default_nettype wire

// ---- testbench.sv ----
// testbench: directed tests for the shared pin port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import spp_pkg::*;
   // ======================================================================
   // stimulus and observation
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic routed_oe = 0, routed_out = 0, pready, pslverr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0] a_oe = '0, a_out = '0, b_oe = '0, b_out = '0, pad_in = '0;
   logic [7:0] periph_in, pad_out, pad_oe;
   int n_fail = 0, compares = 0;
   spp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_a_oe(a_oe), .periph_a_out(a_out), .periph_b_oe(b_oe),
      .periph_b_out(b_out), .routed_oe(routed_oe), .routed_out(routed_out),
      .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
   initial forever #12.5 pclk = ~pclk;
   // ======================================================================
   // shared tasks
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // request held until pready seen at a rising edge, then released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // pad outputs land one edge after the write; two gives margin
   task automatic pins(input logic [7:0] oe, input logic [7:0] out);
      repeat (2) @(posedge pclk);
      chk(pad_oe, oe, "pad direction");
      chk(pad_out & pad_oe, out, "pad value");
   endtask
   // ======================================================================
   // scenarios
   task automatic t_reset;
      apb(1'b0, SPP_OFF_DIRECTION, 32'h0);
      chk(rd[7:0], 8'h00, "direction reset");
      chk(pad_oe, 8'h00, "pads idle");
      $display("test reset done");
   endtask
   task automatic t_gen_out;
      apb(1'b1, SPP_OFF_DIRECTION, 32'hA5);
      apb(1'b1, SPP_OFF_GEN_OUT_DATA, 32'h3C);
      pins(8'hA5, 8'h24);
      $display("test general output done");
   endtask
   task automatic t_prio;
      a_oe <= 8'h0A; a_out <= 8'h0F; b_oe <= 8'h30; b_out <= 8'h70;
      apb(1'b1, SPP_OFF_PERIPH_EN, 32'h7F);
      pins(8'hBA, 8'h3A);
      apb(1'b1, SPP_OFF_PERIPH_EN, 32'h70);
      pins(8'hB5, 8'h34);
      $display("test priority done");
   endtask
   task automatic t_route;
      routed_oe <= 1'b1;
      routed_out <= 1'b1;
      apb(1'b1, SPP_OFF_PERIPH_EN, 32'h80);
      apb(1'b1, SPP_OFF_ROUTE_SEL, 32'h3);
      pins(8'hAD, 8'h2C);
      apb(1'b1, SPP_OFF_ROUTE_SEL, 32'h6);
      pins(8'hE5, 8'h64);
      $display("test routing done");
   endtask
   task automatic t_input;
      pad_in <= 8'h96;
      repeat (6) @(posedge pclk);
      chk(periph_in, 8'h96, "peripheral view");
      apb(1'b0, SPP_OFF_READBACK, 32'h0);
      chk(rd[7:0], 8'h96, "readback on outputs");
      apb(1'b0, 12'h020, 32'h0);
      chk({7'h00, err}, 8'h01, "unmapped error");
      chk(rd[7:0], 8'h00, "unmapped data");
      $display("test input done");
   endtask
   // ======================================================================
   // main sequence and watchdog
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gen_out();
      t_prio();
      t_route();
      t_input();
      print_verdict();
   end
   initial begin
      #20000;
      n_fail++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
